// ---- hdl/spi_quirks_pkg.sv ----
/*
  Shared constants, carrier structs and state codes for the serial
  peripheral master. Assumes a single system clock drives every user.
*/
package spi_quirks_pkg;

  // ---------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------
  localparam int         CS_COUNT     = 4;
  localparam int         DATA_W       = 16;
  localparam int         FIFO_DEPTH   = 32;
  localparam logic [3:0] CS_ALL_OFF   = 4'hf;
  localparam logic [3:0] CS_ONE_HOT   = 4'h1;
  localparam logic [7:0] DIV_FAST     = 8'h01;
  localparam logic [3:0] WIDTH_8      = 4'h0;   // Width field value for 8 bits.
  localparam logic [3:0] ALIGN_BASE   = 4'h8;   // Left shift for an 8-bit word.
  localparam logic [5:0] HALF_BASE    = 6'h10;  // Half periods of an 8-bit word.
  localparam logic [8:0] IDLE_MAX     = 9'h1ff;
  localparam logic [1:0] EXTRA_HALVES = 2'h2;   // One whole spurious pulse.
  localparam logic       ENABLE_RST   = 1'b0;
  localparam logic       FLAG_RST     = 1'b0;
  localparam logic       LAST_FAST_RST = 1'b1;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // Per chip select configuration.
  typedef struct packed {
    logic [7:0] baud_divider_field;
    logic       clock_polarity_bit;
    logic       clock_phase_bit;
    logic [3:0] width_field;             // Bits per transfer minus 8.
    logic       cs_hold_after_transfer;
    logic [7:0] between_transfer_delay;
    logic [7:0] between_select_delay;
  } cs_cfg_t;

  // One transmit data register write.
  typedef struct packed {
    logic              final_transfer_flag;
    logic [1:0]        cs;
    logic [DATA_W-1:0] data;
  } tx_word_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h1,
    ST_SEL_GAP  = 4'h2,
    ST_SHIFT    = 4'h4,
    ST_XFER_GAP = 4'h8
  } state_t;

endpackage

// ---- hdl/serial_peripheral_master_quirks.sv ----
/*
  Serial peripheral master with chip select sequencing, a transmit word
  FIFO and the transfer quirks of one silicon revision. Assumes all
  command and configuration inputs are synchronous to i_clock; only the
  serial data input comes from a pin.
*/
`timescale 1ns/10ps

// -----------------------------------------------------------------
// Transmit word FIFO
// -----------------------------------------------------------------
module tx_word_fifo #(
  parameter int WIDTH = $bits(spi_quirks_pkg::tx_word_t),
  parameter int DEPTH = spi_quirks_pkg::FIFO_DEPTH
) (
  // Clock, reset and flush.
  input  wire logic             i_clock,
  input  wire logic             i_rstn,
  input  wire logic             i_clear,
  // Filling side.
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Draining side.
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  logic [AW:0]      next_cnt;
  logic             push;
  logic             pull;

  // Flags are registered so the ready output comes from a flop.
  assign push       = i_in_valid && o_in_ready;
  assign pull       = o_out_valid && i_out_ready;
  assign next_cnt   = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pull};
  assign o_out_data = mem[rp];

  // Pointers and occupancy.
  always_ff @(posedge i_clock) begin
    if (!i_rstn || i_clear) begin
      wp          <= '0;
      rp          <= '0;
      cnt         <= '0;
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      wp          <= wp + AW'(push);
      rp          <= rp + AW'(pull);
      cnt         <= next_cnt;
      o_in_ready  <= next_cnt != (AW+1)'(DEPTH);
      o_out_valid <= next_cnt != '0;
    end
  end

  // Storage needs no reset.
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wp] <= i_in_data;
    end
  end
endmodule

// -----------------------------------------------------------------
// Master engine
// -----------------------------------------------------------------
// Summary of operation
// - Master mode with an odd divider other than 1, polarity 1 and phase 0 adds one clock pulse.
// - Held chip select, divider 1 and an idle gap to the same slave keep transmit-ready low.
// - In fixed mode with hold, a final-transfer word releases the select when empty sets.
// - The serial clock idles at the polarity of the configuration even before master select.
// - In fixed mode the reported DMA size follows chip select 0's width field.
// - A divider of 1 with an odd width adds one clock pulse; even widths are clean except right after a slow transfer at polarity 1, phase 0.
// - Disable is ignored in slave mode; software reads data and then resets instead.
// - Software reset keeps the enable state, so a later enable raises no flags.
// - With a held select and a long idle, a switch to another slave skips the select gap.
// - Polarity 1, phase 0, a slow transfer then a divider-1 one adds a pulse to the second.
// - When every select uses divider 1 the cross-select pulse never appears.
module serial_peripheral_master_quirks (
  // Clock and reset.
  input  wire logic                     i_clock,
  input  wire logic                     i_rstn,
  // Mode and commands.
  input  wire logic                     i_master_select_bit,
  input  wire logic                     i_fixed_mode,
  input  wire logic [1:0]               i_fixed_cs,
  input  wire logic                     i_enable_cmd,
  input  wire logic                     i_disable_cmd,
  input  wire logic                     i_swreset_cmd,
  input  wire spi_quirks_pkg::cs_cfg_t [spi_quirks_pkg::CS_COUNT-1:0] i_cs_cfg,
  // Transmit stream.
  input  wire logic                     i_tx_valid,
  input  wire spi_quirks_pkg::tx_word_t i_tx_word,
  output logic                          o_tx_ready,
  // Status.
  output logic                          o_enable_state_bit,
  output logic                          o_transmit_ready,
  output logic                          o_transmit_empty_status,
  output logic                          o_dma_halfword,
  // Receive.
  output logic [spi_quirks_pkg::DATA_W-1:0] o_rx_word,
  output logic                          o_rx_valid,
  // Pins.
  output logic                          o_serial_clock_pin,
  output logic                          o_mosi,
  input  wire logic                     i_miso,
  output logic [spi_quirks_pkg::CS_COUNT-1:0] o_chip_select_n
);
  import spi_quirks_pkg::*;

  state_t            st;
  tx_word_t          f_word;
  cs_cfg_t           cc;
  cs_cfg_t           nc;
  logic              f_valid;
  logic              miso_meta;
  logic              miso_s;
  logic              dummy_loop;
  logic              last_fast;
  logic              cs_on;
  logic              final_cur;
  logic [1:0]        cur_cs;
  logic [1:0]        new_cs;
  logic [1:0]        ext_cnt;
  logic [7:0]        div_cnt;
  logic [7:0]        gap_cnt;
  logic [8:0]        idle_cnt;
  logic [5:0]        half;
  logic [DATA_W-1:0] shreg;
  logic [DATA_W-1:0] rx;
  logic [DATA_W-1:0] aligned;
  logic [CS_COUNT-1:0] fast;
  logic go, tick, need_gap, dup, extra, start, pop, done, long_idle, all_fast;

  // Flags each select whose divider is the fastest setting.
  for (genvar g = 0; g < CS_COUNT; g++) begin : g_fast
    assign fast[g] = i_cs_cfg[g].baud_divider_field == DIV_FAST;
  end
  assign all_fast = &fast;

  // ---------------------------------------------------------------
  // Transfer decisions
  // ---------------------------------------------------------------
  // A transfer in flight uses its own select's settings.
  assign new_cs = dummy_loop ? cur_cs : (i_fixed_mode ? i_fixed_cs : f_word.cs);
  assign cc     = i_cs_cfg[cur_cs];
  assign nc     = i_cs_cfg[new_cs];
  assign go     = dummy_loop || (f_valid && o_enable_state_bit && i_master_select_bit);
  assign long_idle = idle_cnt > ({1'b0, cc.between_transfer_delay}
                                 + {1'b0, cc.between_select_delay});
  // A long idle under a held select drops the between-select gap.
  assign need_gap = cs_on && (new_cs != cur_cs) && !long_idle;
  // The word is shifted but not retired, so it goes out twice.
  assign dup = cs_on && nc.cs_hold_after_transfer && fast[new_cs]
               && (new_cs == cur_cs) && (idle_cnt != '0) && !dummy_loop;
  // Spurious pulse conditions.
  assign extra = (nc.clock_polarity_bit && !nc.clock_phase_bit
                  && !fast[new_cs] && nc.baud_divider_field[0])
              || (fast[new_cs] && nc.width_field[0])
              || (nc.clock_polarity_bit && !nc.clock_phase_bit
                  && fast[new_cs] && !last_fast && !all_fast);
  assign start = go && ((st == ST_IDLE && !need_gap)
                        || (st == ST_SEL_GAP && gap_cnt == '0));
  assign pop   = start && !dup && !dummy_loop;
  assign tick  = ({1'b0, div_cnt} + 9'h001) >= {1'b0, cc.baud_divider_field};
  assign done  = st == ST_SHIFT && tick && ext_cnt == '0
                 && half == ({1'b0, cc.width_field, 1'b0} + HALF_BASE - 6'h01);
  assign aligned = (dummy_loop ? '0 : f_word.data) << (ALIGN_BASE - nc.width_field);
  assign o_mosi  = shreg[DATA_W-1];

  tx_word_fifo #(
    .WIDTH ($bits(tx_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_rstn      (i_rstn),
    .i_clear     (i_swreset_cmd),
    .i_in_valid  (i_tx_valid),
    .i_in_data   (i_tx_word),
    .o_in_ready  (o_tx_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_word),
    .i_out_ready (pop)
  );

  // Two-flop synchroniser for the serial data pin.
  always_ff @(posedge i_clock) begin
    miso_meta <= i_miso;
    miso_s    <= miso_meta;
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // State register.
  always_ff @(posedge i_clock) begin
    if (!i_rstn || i_swreset_cmd) begin
      st <= ST_IDLE;
    end else begin
      unique case (st)
        ST_IDLE: begin
          if (go) begin
            st <= need_gap ? ST_SEL_GAP : ST_SHIFT;
          end
        end
        ST_SEL_GAP: begin
          if (!go) begin
            st <= ST_IDLE;
          end else if (gap_cnt == '0) begin
            st <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (done) begin
            st <= ST_XFER_GAP;
          end
        end
        ST_XFER_GAP: begin
          if (gap_cnt == '0) begin
            st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Gap, baud and idle counters.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      gap_cnt  <= '0;
      div_cnt  <= '0;
      idle_cnt <= '0;
    end else begin
      if (st == ST_IDLE && go && need_gap) begin
        gap_cnt <= nc.between_select_delay;
      end else if (done) begin
        gap_cnt <= cc.between_transfer_delay;
      end else if (gap_cnt != '0) begin
        gap_cnt <= gap_cnt - 8'h01;
      end
      div_cnt  <= (start || tick || st != ST_SHIFT) ? '0 : div_cnt + 8'h01;
      idle_cnt <= (st != ST_IDLE) ? '0 : idle_cnt + 9'(idle_cnt != IDLE_MAX);
    end
  end

  // Shifter; a phase-0 load sits one place low so the first edge shifts in.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      shreg     <= '0;
      rx        <= '0;
      half      <= '0;
      ext_cnt   <= '0;
      final_cur <= 1'b0;
      last_fast <= LAST_FAST_RST;
    end else if (start) begin
      shreg     <= nc.clock_phase_bit ? aligned : aligned >> 1;
      rx        <= '0;
      half      <= '0;
      ext_cnt   <= extra ? EXTRA_HALVES : 2'h0;
      final_cur <= !dummy_loop && f_word.final_transfer_flag;
      last_fast <= fast[new_cs];
    end else if (st == ST_SHIFT && tick) begin
      if (ext_cnt != '0) begin
        ext_cnt <= ext_cnt - 2'h1;
      end else begin
        half <= half + 6'h01;
        if (!half[0] == cc.clock_phase_bit) begin
          rx <= {rx[DATA_W-2:0], miso_s};
        end else begin
          shreg <= shreg << 1;
        end
      end
    end
  end

  // Clock pin idles at the live polarity, master select or not.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_serial_clock_pin <= 1'b0;
    end else if (st == ST_SHIFT && tick) begin
      o_serial_clock_pin <= !o_serial_clock_pin;
    end else if (st != ST_SHIFT) begin
      o_serial_clock_pin <= cc.clock_polarity_bit;
    end
  end

  // Chip select lines.
  always_ff @(posedge i_clock) begin
    if (!i_rstn || i_swreset_cmd) begin
      o_chip_select_n <= CS_ALL_OFF;
      cs_on           <= 1'b0;
      cur_cs          <= '0;
    end else if (st == ST_IDLE && go && need_gap) begin
      o_chip_select_n <= CS_ALL_OFF;
      cs_on           <= 1'b0;
    end else if (start) begin
      o_chip_select_n <= ~(CS_ONE_HOT << new_cs);
      cs_on           <= 1'b1;
      cur_cs          <= new_cs;
    end else if (done && (!cc.cs_hold_after_transfer || final_cur)) begin
      o_chip_select_n <= CS_ALL_OFF;
      cs_on           <= 1'b0;
    end
  end

  // Received word; a final trailing-edge sample is folded in here.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_rx_word  <= '0;
      o_rx_valid <= 1'b0;
    end else begin
      o_rx_valid <= done;
      if (done) begin
        o_rx_word <= cc.clock_phase_bit ? rx : {rx[DATA_W-2:0], miso_s};
      end
    end
  end

  // Enable state and transmit flags; the reset command spares enable.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_enable_state_bit      <= ENABLE_RST;
      o_transmit_ready        <= FLAG_RST;
      o_transmit_empty_status <= FLAG_RST;
      dummy_loop              <= 1'b0;
    end else if (i_swreset_cmd) begin
      o_transmit_ready        <= FLAG_RST;
      o_transmit_empty_status <= FLAG_RST;
      dummy_loop              <= 1'b0;
    end else if (i_enable_cmd && !o_enable_state_bit) begin
      o_enable_state_bit      <= 1'b1;
      o_transmit_ready        <= 1'b1;
      o_transmit_empty_status <= 1'b1;
    end else if (i_disable_cmd && i_master_select_bit) begin
      o_enable_state_bit      <= 1'b0;
      o_transmit_ready        <= 1'b0;
      o_transmit_empty_status <= 1'b0;
      dummy_loop              <= dummy_loop || st != ST_IDLE;
    end else begin
      if (start && dup) begin
        o_transmit_ready <= 1'b0;
      end else if (pop) begin
        o_transmit_ready <= 1'b1;
      end else if (!o_tx_ready) begin
        o_transmit_ready <= 1'b0;
      end
      if (start) begin
        o_transmit_empty_status <= 1'b0;
      end else if (done && !f_valid && !dummy_loop) begin
        o_transmit_empty_status <= 1'b1;
      end
    end
  end

  // Size reported to the DMA engine.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_dma_halfword <= 1'b0;
    end else begin
      o_dma_halfword <= (i_fixed_mode ? i_cs_cfg[0].width_field
                                      : cc.width_field) != WIDTH_8;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [3:0] cs0_width;
  assign cs0_width = i_cs_cfg[0].width_field;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn || i_swreset_cmd);

  sequence s_load;
    start && !i_enable_cmd && !i_disable_cmd;
  endsequence
  sequence s_slow_fast;
    s_load ##0 (!last_fast && fast[new_cs] && nc.clock_polarity_bit
                && !nc.clock_phase_bit && !all_fast);
  endsequence

  property p_odd_divider_pulse;
    s_load ##0 (nc.clock_polarity_bit && !nc.clock_phase_bit && !fast[new_cs]
                && nc.baud_divider_field[0]) |=> ext_cnt == EXTRA_HALVES;
  endproperty
  a_odd_divider_pulse: assert property (p_odd_divider_pulse)
    else $error("odd divider did not add a pulse");
  property p_dup_ready_low;
    (s_load ##0 dup) |=> !o_transmit_ready ##0 f_valid;
  endproperty
  a_dup_ready_low: assert property (p_dup_ready_low)
    else $error("repeated word raised transmit ready");
  property p_final_release;
    done && final_cur |=> o_chip_select_n == CS_ALL_OFF;
  endproperty
  a_final_release: assert property (p_final_release)
    else $error("final word left the select asserted");
  property p_dma_size;
    i_fixed_mode |=> o_dma_halfword == ($past(cs0_width) != WIDTH_8);
  endproperty
  a_dma_size: assert property (p_dma_size)
    else $error("dma size did not follow select zero");
  property p_odd_width_pulse;
    s_load ##0 (fast[new_cs] && nc.width_field[0]) |=> ext_cnt == EXTRA_HALVES;
  endproperty
  a_odd_width_pulse: assert property (p_odd_width_pulse)
    else $error("odd width at divider one gave no pulse");
  property p_slave_disable;
    i_disable_cmd && !i_master_select_bit && !i_enable_cmd
      |=> o_enable_state_bit == $past(o_enable_state_bit);
  endproperty
  a_slave_disable: assert property (p_slave_disable)
    else $error("disable acted in slave mode");
  property p_reset_keeps_enable;
    disable iff (!i_rstn) i_swreset_cmd && o_enable_state_bit |=> o_enable_state_bit;
  endproperty
  a_reset_keeps_enable: assert property (p_reset_keeps_enable)
    else $error("software reset cleared the enable state");
  property p_direct_switch;
    st == ST_IDLE && go && cs_on && new_cs != cur_cs && long_idle
      |=> st == ST_SHIFT ##0 o_chip_select_n != CS_ALL_OFF;
  endproperty
  a_direct_switch: assert property (p_direct_switch)
    else $error("long idle switch inserted a select gap");
  property p_slow_fast_pulse;
    s_slow_fast |=> ext_cnt == EXTRA_HALVES ##1 st == ST_SHIFT;
  endproperty
  a_slow_fast_pulse: assert property (p_slow_fast_pulse)
    else $error("slow then fast transfer gave no pulse");
  property p_all_fast_clean;
    s_load ##0 (all_fast && !nc.width_field[0]) |=> ext_cnt == '0;
  endproperty
  a_all_fast_clean: assert property (p_all_fast_clean)
    else $error("all-fast selects produced a pulse");
endmodule

// ---- verification/serial_slave_model.sv ----
/*
  Behavioural serial slave for the master bench: counts serial clock
  edges in each frame and returns a preset pattern, then the shifted-in data, on the data line.
  Assumes the master drives clock and selects from i_clock flops.
*/
`timescale 1ns/10ps

module serial_slave_model (
  // Clock and reset.
  input  wire logic       i_clock,
  input  wire logic       i_rstn,
  // Serial pins.
  input  wire logic       i_sck,
  input  wire logic [3:0] i_cs_n,
  input  wire logic       i_mosi,
  output logic            o_miso,
  // Observation.
  output logic [7:0]      o_frame_toggles
);
  logic        sck_q;
  logic [3:0]  cs_q;
  logic [7:0]  count;
  logic [15:0] shift;

  // -----------------------------------------------------------------
  // Frame tracking
  // -----------------------------------------------------------------
  // A released data line flips every cycle so that no stale bit can pass.
  // The last clock edge lands together with the select release, so the
  // select level of the previous cycle still admits it to the count.
  always_ff @(posedge i_clock) begin
    sck_q <= i_sck;
    cs_q  <= i_cs_n;
    if (!i_rstn) begin
      count           <= 8'h00;
      o_frame_toggles <= 8'h00;
      o_miso          <= 1'b0;
      shift           <= 16'ha5c3;
    end else begin
      if (i_sck != sck_q && (i_cs_n != 4'hf || cs_q != 4'hf)) begin
        count <= count + 8'h01;
        shift <= {shift[14:0], i_mosi};
      end
      if (i_cs_n != 4'hf) begin
        o_frame_toggles <= 8'h00;
        o_miso          <= shift[15];
      end else begin
        if (cs_q == 4'hf && count != 8'h00) begin
          o_frame_toggles <= count;
          count           <= 8'h00;
        end
        o_miso <= ~o_miso;
      end
    end
  end
endmodule

// ---- verification/serial_peripheral_master_quirks_bench.sv ----
/*
  Self-checking bench for the serial peripheral master. Assumes the
  package and design are compiled first and the slave model beside it.
*/
`timescale 1ns/10ps

module serial_peripheral_master_quirks_bench;
  import spi_quirks_pkg::*;

  // -----------------------------------------------------------------
  // Signals
  // -----------------------------------------------------------------
  logic                   i_clock;
  logic                   i_rstn;
  logic                   master;
  logic                   fixed_mode;
  logic [1:0]             fixed_cs;
  logic                   en_cmd, dis_cmd, rst_cmd;
  cs_cfg_t [CS_COUNT-1:0] cfg;
  logic                   tx_valid;
  tx_word_t               tx_word;
  logic                   tx_ready, enabled, ready, empty, halfword;
  logic                   rx_valid, sck, mosi, miso;
  logic [DATA_W-1:0]      rx_word;
  logic [CS_COUNT-1:0]    cs_n;
  logic [7:0]             toggles;
  int                     fail_count = 0;
  int                     compares = 0;
  int                     cycles = 0;

  serial_peripheral_master_quirks dut_u (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_master_select_bit(master),
    .i_fixed_mode(fixed_mode), .i_fixed_cs(fixed_cs), .i_enable_cmd(en_cmd),
    .i_disable_cmd(dis_cmd), .i_swreset_cmd(rst_cmd), .i_cs_cfg(cfg),
    .i_tx_valid(tx_valid), .i_tx_word(tx_word), .o_tx_ready(tx_ready),
    .o_enable_state_bit(enabled), .o_transmit_ready(ready),
    .o_transmit_empty_status(empty), .o_dma_halfword(halfword),
    .o_rx_word(rx_word), .o_rx_valid(rx_valid), .o_serial_clock_pin(sck),
    .o_mosi(mosi), .i_miso(miso), .o_chip_select_n(cs_n));

  serial_slave_model slave_u (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_sck(sck), .i_cs_n(cs_n),
    .i_mosi(mosi), .o_miso(miso), .o_frame_toggles(toggles));

  // -----------------------------------------------------------------
  // Clock and hang guard
  // -----------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // The whole run needs well under a thousand cycles; the ceiling leaves room.
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // Pulses {software reset, disable, enable} for one cycle, then lets flags land.
  task automatic cmd(input logic [2:0] c);
    @(negedge i_clock);
    {rst_cmd, dis_cmd, en_cmd} = c;
    @(negedge i_clock);
    {rst_cmd, dis_cmd, en_cmd} = 3'b000;
    repeat (2) @(negedge i_clock);
  endtask

  task automatic send(input tx_word_t w);
    @(negedge i_clock);
    tx_valid = 1'b1;
    tx_word  = w;
    do @(posedge i_clock); while (tx_ready !== 1'b1);
    @(negedge i_clock);
    tx_valid = 1'b0;
  endtask

  // Leaves the caller at the falling edge inside the receive pulse.
  task automatic wait_rx();
    for (int n = 0; n < 3000 && rx_valid !== 1'b1; n++) @(negedge i_clock);
    check(rx_valid, 1'b1, "transfer never finished");
  endtask

  // One transfer on a select without hold; frame edges are 2 per bit plus 2 per extra pulse.
  task automatic xfer(input logic [1:0] cs, input logic [7:0] div, input logic pol,
                      input logic pha, input logic [3:0] wf, input logic extra);
    logic [31:0] exp;
    exp = 32'(2 * (8 + wf)) + (extra ? 32'h2 : 32'h0);
    @(negedge i_clock);
    cfg[cs] = '{div, pol, pha, wf, 1'b0, 8'h02, 8'h02};
    send('{1'b0, cs, 16'hc35a});
    wait_rx();
    repeat (4) @(negedge i_clock);
    check(toggles, exp, "clock edges in frame");
  endtask

  task automatic conclude();
    $display("compares %0d failures %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    check(cs_n, 4'hf, "selects after reset");
    check(tx_ready, 1'b1, "fifo ready after reset");
    check({enabled, ready, empty}, 3'b000, "flags after reset");
    cmd(3'b001);
    check({enabled, ready, empty}, 3'b111, "flags after enable");
  endtask

  // Slow then fast selects, odd dividers and odd widths decide the extra pulse.
  task automatic t_pulses();
    xfer(2'd0, 8'h02, 1'b0, 1'b1, 4'h0, 1'b0);
    xfer(2'd0, 8'h03, 1'b1, 1'b0, 4'h0, 1'b1);
    xfer(2'd1, 8'h01, 1'b1, 1'b0, 4'h0, 1'b1);
    for (int k = 0; k < CS_COUNT; k++) cfg[k].baud_divider_field = DIV_FAST;
    xfer(2'd1, 8'h01, 1'b1, 1'b0, 4'h0, 1'b0);
    xfer(2'd2, 8'h01, 1'b1, 1'b1, 4'h1, 1'b1);
    xfer(2'd2, 8'h01, 1'b1, 1'b1, 4'h2, 1'b0);
  endtask

  task automatic t_dma_size();
    @(negedge i_clock);
    fixed_mode = 1'b1;
    fixed_cs   = 2'd1;
    cfg[1].width_field = WIDTH_8;
    cfg[0].width_field = 4'h2;
    repeat (3) @(negedge i_clock);
    check(halfword, 1'b1, "size follows select zero");
    cfg[0].width_field = WIDTH_8;
    repeat (3) @(negedge i_clock);
    check(halfword, 1'b0, "byte size restored");
  endtask

  // Fixed mode with hold: only a word flagged final lets the select go.
  task automatic t_final_flag();
    @(negedge i_clock);
    fixed_cs = 2'd0;
    cfg[0]   = '{8'h02, 1'b1, 1'b1, WIDTH_8, 1'b1, 8'h02, 8'h02};
    send('{1'b0, 2'd0, 16'h1234});
    wait_rx();
    check(cs_n, 4'he, "select held between words");
    cfg[1] = cfg[0];
    repeat (8) @(negedge i_clock);
    fixed_cs = 2'd1;
    send('{1'b1, 2'd1, 16'h5678});
    repeat (2) @(negedge i_clock);
    check(cs_n, 4'hd, "long idle switches selects directly");
    wait_rx();
    check({empty, cs_n}, 5'h1f, "select released with empty");
    fixed_mode = 1'b0;
  endtask

  // Hold with divider one breaks the software rule on purpose to show the repeat.
  task automatic t_dup();
    @(negedge i_clock);
    cfg[3] = '{DIV_FAST, 1'b0, 1'b1, WIDTH_8, 1'b1, 8'h00, 8'h00};
    send('{1'b0, 2'd3, 16'h00a5});
    wait_rx();
    repeat (3) @(negedge i_clock);
    send('{1'b1, 2'd3, 16'h005a});
    wait_rx();
    check(ready, 1'b0, "repeated word kept ready low");
    @(negedge i_clock);
    wait_rx();
    check({ready, cs_n}, 5'h1f, "word sent again then released");
  endtask

  task automatic t_enable_quirks();
    @(negedge i_clock);
    master = 1'b0;
    cmd(3'b010);
    check(enabled, 1'b1, "disable ignored as slave");
    master = 1'b1;
    cmd(3'b100);
    check(enabled, 1'b1, "reset keeps enable state");
    cmd(3'b001);
    check({ready, empty}, 2'b00, "enable after reset raises nothing");
    cmd(3'b010);
    check(enabled, 1'b0, "disable as master");
    cmd(3'b001);
    check({enabled, ready, empty}, 3'b111, "enable after disable");
  endtask

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  // Master select is set before any select configuration is touched.
  initial begin
    i_rstn = 1'b0;
    master = 1'b1;
    fixed_mode = 1'b0;
    fixed_cs = 2'd0;
    {rst_cmd, dis_cmd, en_cmd} = 3'b000;
    cfg = '0;
    tx_valid = 1'b0;
    tx_word = '0;
    repeat (20) @(negedge i_clock);
    i_rstn = 1'b1;
    @(negedge i_clock);
    t_reset();
    t_pulses();
    t_dma_size();
    t_final_flag();
    t_dup();
    t_enable_quirks();
    conclude();
  end
endmodule
